// ==== design/vis_pkg.sv ====
// package: constants and carriers for the vectored interrupt sequencer
package vis_pkg;
  localparam int          VIS_PC_W        = 9;
  localparam int          VIS_SP_W        = 8;
  localparam int          VIS_NSRC        = 9;
  localparam int          VIS_GIE_BIT     = 7;
  localparam logic [7:0]  VIS_STATUS_RST  = 8'h00;
  localparam logic [7:0]  VIS_SP_RST      = 8'h9f;
  localparam logic [8:0]  VIS_RESET_VEC   = 9'h000;
  localparam int          VIS_CLK_MHZ     = 50;
  localparam int          VIS_ENTRY_NS    = 80;
  localparam int          VIS_RETURN_NS   = 80;
  localparam int          VIS_WAKE_NS     = 80;
  localparam int          VIS_ENTRY_CYC   =
    (VIS_ENTRY_NS * VIS_CLK_MHZ + 999) / 1000;
  localparam int          VIS_RETURN_CYC  =
    (VIS_RETURN_NS * VIS_CLK_MHZ) / 1000;
  localparam int          VIS_WAKE_CYC    =
    (VIS_WAKE_NS * VIS_CLK_MHZ + 999) / 1000;
  localparam int          VIS_SP_STEP     = 2;

  typedef enum logic [1:0] {
    VIS_CMD_NONE,
    VIS_CMD_SET_GIE,
    VIS_CMD_CLR_GIE,
    VIS_CMD_RETURN
  } vis_cmd_t;

  // one instruction boundary report from the pipeline
  typedef struct packed {
    logic      boundary;
    logic      multi_busy;
    vis_cmd_t  cmd;
    logic      status_we;
    logic [7:0] status_wdata;
    logic      sleeping;
  } vis_core_t;

  // stack access request toward the data memory
  typedef struct packed {
    logic       we;
    logic       re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vis_stack_t;
endpackage : vis_pkg

// ==== design/vis_prio.sv ====
// fixed priority picker: lowest index wins
`timescale 1ns/10ps
`default_nettype none
module vis_prio
  import vis_pkg::*;
#(
  parameter int N = VIS_NSRC
) (
  input  wire logic [N-1:0]         req,
  output logic                      any,
  output logic [$clog2(N+1)-1:0]    idx
);
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = ($clog2(N+1))'(i);
      end
    end
  end
endmodule : vis_prio
`default_nettype wire

// ==== design/vis_seq.sv ====
// interrupt arbitration, handler entry and return sequencing
`timescale 1ns/10ps
`default_nettype none
module vis_seq
  import vis_pkg::*;
#(
  parameter int                NSRC     = VIS_NSRC,
  parameter logic [NSRC-1:0]   LEVEL_SRC = '0
) (
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  input  wire vis_core_t          core,
  input  wire logic [VIS_PC_W-1:0] pc_in,
  input  wire logic [NSRC-1:0]    src_event,
  input  wire logic [NSRC-1:0]    src_level,
  input  wire logic [NSRC-1:0]    src_enable,
  input  wire logic [NSRC-1:0]    flag_clear_wr,
  input  wire logic               sp_we,
  input  wire logic [VIS_SP_W-1:0] sp_wdata,
  input  wire logic [7:0]         stack_rdata,
  output logic [NSRC-1:0]         flag_out,
  output logic [7:0]              processor_status_register,
  output logic [VIS_SP_W-1:0]     sp_out,
  output vis_stack_t              stack_req,
  output logic                    core_stall,
  output logic                    pc_load,
  output logic [VIS_PC_W-1:0]     program_counter,
  output logic                    in_entry,
  output logic                    in_return
);
  localparam int IW = $clog2(NSRC + 1);
  localparam logic [2:0] ENTRY_LAST  = 3'(VIS_ENTRY_CYC - 1);
  localparam logic [2:0] RETURN_LAST = 3'(VIS_RETURN_CYC - 1);
  localparam logic [2:0] WAKE_LAST   = 3'(VIS_WAKE_CYC - 1);

  typedef enum logic [2:0] {
    VIS_RUN, VIS_WAKE, VIS_ENTRY, VIS_RETURN
  } vis_state_t;

  typedef struct packed {
    vis_state_t             st;
    logic [2:0]             cnt;
    logic [NSRC-1:0]        flag;
    logic [7:0]             status;
    logic [VIS_SP_W-1:0]    sp;
    logic [VIS_PC_W-1:0]    pc;
    logic [VIS_PC_W-1:0]    ret_pc;
    logic [IW-1:0]          vec;
    logic                   hold_one;
    logic                   load;
    vis_stack_t             stk;
    logic [NSRC-1:0]        ev_s1;
    logic [NSRC-1:0]        ev_s2;
    logic [NSRC-1:0]        ev_s3;
    logic [NSRC-1:0]        lv_s1;
    logic [NSRC-1:0]        lv_s2;
  } vis_regs_t;

  vis_regs_t s_reg;
  vis_regs_t s_next;

  function automatic logic [VIS_PC_W-1:0] vec_addr(input logic [IW-1:0] v);
    // index 0 is reset, sources start at word 1
    vec_addr = VIS_RESET_VEC + VIS_PC_W'(v) + VIS_PC_W'(1);
  endfunction : vec_addr

  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] req;
  logic            req_any;
  logic [IW-1:0]   req_idx;
  logic [NSRC-1:0] ev_rise;
  logic            gie_now;

  always_comb begin
    ev_rise = s_reg.ev_s2 & ~s_reg.ev_s3;
    // edge sources from the flag, level sources from the synchronised pin (lv_s2)
    pend = (s_reg.flag & ~LEVEL_SRC) | (s_reg.lv_s2 & LEVEL_SRC);
    // a clear-enable in this cycle masks requests at once
    gie_now = s_reg.status[VIS_GIE_BIT] &&
              core.cmd != VIS_CMD_CLR_GIE;
    req = pend & src_enable & {NSRC{gie_now}};
  end

  vis_prio #(.N(NSRC)) u_prio (
    .req (req),
    .any (req_any),
    .idx (req_idx)
  );

  always_comb begin
    s_next = s_reg;
    s_next.ev_s1 = src_event;
    s_next.ev_s2 = s_reg.ev_s1;
    s_next.ev_s3 = s_reg.ev_s2;
    s_next.lv_s1 = src_level;
    s_next.lv_s2 = s_reg.lv_s1;
    s_next.load = 1'b0;
    s_next.stk = '0;
    s_next.flag = s_reg.flag & ~flag_clear_wr;
    if (sp_we) begin
      s_next.sp = sp_wdata;
    end
    if (core.status_we) begin
      // status register is written whole by software here; the GIE updates below override bit 7
      s_next.status = core.status_wdata;
    end
    unique case (s_reg.st)
      VIS_RUN: begin
        if (core.boundary) begin
          if (core.cmd == VIS_CMD_SET_GIE) begin
            s_next.status[VIS_GIE_BIT] = 1'b1;
            s_next.hold_one = 1'b1;
          end else if (core.cmd == VIS_CMD_CLR_GIE) begin
            s_next.status[VIS_GIE_BIT] = 1'b0;
            s_next.hold_one = 1'b0;
          end else if (core.cmd == VIS_CMD_RETURN) begin
            s_next.st = VIS_RETURN;
            s_next.cnt = '0;
            s_next.stk.re = 1'b1;
            s_next.stk.addr = 8'(s_reg.sp + 8'h01);
          end else if (s_reg.hold_one) begin
            s_next.hold_one = 1'b0;
          end else if (req_any && !core.multi_busy) begin
            s_next.vec = req_idx;
            s_next.ret_pc = pc_in;
            s_next.status[VIS_GIE_BIT] = 1'b0;
            s_next.cnt = '0;
            s_next.st = core.sleeping ? VIS_WAKE : VIS_ENTRY;
            if (!LEVEL_SRC[req_idx]) begin
              s_next.flag[req_idx] = 1'b0;
            end
          end
        end
      end
      VIS_WAKE: begin
        s_next.cnt = s_reg.cnt + 3'h1;
        if (s_reg.cnt == WAKE_LAST) begin
          s_next.cnt = '0;
          s_next.st = VIS_ENTRY;
        end
      end
      VIS_ENTRY: begin
        s_next.cnt = s_reg.cnt + 3'h1;
        if (s_reg.cnt == 3'h0) begin
          s_next.stk.we = 1'b1;
          s_next.stk.addr = s_reg.sp;
          s_next.stk.wdata = s_reg.ret_pc[7:0];
        end else if (s_reg.cnt == 3'h1) begin
          s_next.stk.we = 1'b1;
          s_next.stk.addr = 8'(s_reg.sp - 8'h01);
          s_next.stk.wdata = 8'(s_reg.ret_pc[VIS_PC_W-1:8]);
          s_next.sp = 8'(s_reg.sp - 8'(VIS_SP_STEP));
        end
        if (s_reg.cnt == ENTRY_LAST) begin
          s_next.pc = vec_addr(s_reg.vec);
          s_next.load = 1'b1;
          s_next.st = VIS_RUN;
        end
      end
      VIS_RETURN: begin
        s_next.cnt = s_reg.cnt + 3'h1;
        if (s_reg.cnt == 3'h0) begin
          s_next.stk.re = 1'b1;
          s_next.stk.addr = 8'(s_reg.sp + 8'h02);
          s_next.pc[VIS_PC_W-1:8] = stack_rdata[VIS_PC_W-9:0];
        end else if (s_reg.cnt == 3'h1) begin
          s_next.pc[7:0] = stack_rdata;
          s_next.sp = 8'(s_reg.sp + 8'(VIS_SP_STEP));
        end
        if (s_reg.cnt == RETURN_LAST) begin
          s_next.status[VIS_GIE_BIT] = 1'b1;
          s_next.hold_one = 1'b1;
          s_next.load = 1'b1;
          s_next.st = VIS_RUN;
        end
      end
    endcase
    // a new event beats a clear in the same cycle
    s_next.flag = s_next.flag | ev_rise;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
      s_reg.st <= VIS_RUN;
      s_reg.status <= VIS_STATUS_RST;
      s_reg.sp <= VIS_SP_RST;
      s_reg.pc <= VIS_RESET_VEC;
    end else begin
      s_reg <= s_next;
    end
  end

  assign flag_out = s_reg.flag;
  assign processor_status_register = s_reg.status;
  assign sp_out = s_reg.sp;
  assign stack_req = s_reg.stk;
  assign core_stall = s_reg.st != VIS_RUN;
  assign pc_load = s_reg.load;
  assign program_counter = s_reg.pc;
  assign in_entry = s_reg.st == VIS_ENTRY;
  assign in_return = s_reg.st == VIS_RETURN;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_clr_blocks: assert property (
    core.boundary && core.cmd == VIS_CMD_CLR_GIE && s_reg.st == VIS_RUN
    |=> s_reg.st == VIS_RUN) else $error("entry taken on disable");
  a_entry_len: assert property (
    $rose(in_entry) |-> in_entry [*4] ##1 pc_load)
    else $error("entry length wrong");
  a_ret_len: assert property (
    $rose(in_return) |-> in_return [*4] ##1 (pc_load &&
    processor_status_register[VIS_GIE_BIT])) else $error("return bad");
  a_gie_clears: assert property (
    $rose(core_stall) && !in_return |-> !processor_status_register[7])
    else $error("gie not cleared");
  a_sp_push: assert property (
    $rose(in_entry) |-> ##2 sp_out == 8'($past(sp_out, 2) - 8'h02))
    else $error("push step wrong");
  a_sp_pop: assert property (
    $rose(in_return) |-> ##2 sp_out == 8'($past(sp_out, 2) + 8'h02))
    else $error("pop step wrong");
  a_one_instr: assert property (
    $fell(in_return) |-> s_reg.hold_one ##1 !in_entry)
    else $error("no gap after return");
  a_vec_range: assert property (
    pc_load && $past(in_entry) |-> program_counter > VIS_RESET_VEC)
    else $error("vector hits reset");
  a_wake_len: assert property (
    $rose(core_stall) && !in_entry && !in_return |-> !in_entry [*4]
    ##1 in_entry) else $error("wake length wrong");
  a_flag_hold: assert property (
    |ev_rise |=> |(flag_out & $past(ev_rise)))
    else $error("event lost");

  // entry decisions: the gates that must hold a boundary back
  a_take_gated: assert property (
    core.boundary && s_reg.st == VIS_RUN && !gie_now &&
    core.cmd != VIS_CMD_RETURN
    |=> s_reg.st == VIS_RUN)
    else $error("entry without global enable");
  a_src_gated: assert property (
    core.boundary && s_reg.st == VIS_RUN && core.cmd == VIS_CMD_NONE &&
    !(|(pend & src_enable))
    |=> !core_stall)
    else $error("entry without enabled source");
  a_gie_clr_now: assert property (
    core.boundary && s_reg.st == VIS_RUN && core.cmd == VIS_CMD_CLR_GIE
    |=> !processor_status_register[VIS_GIE_BIT])
    else $error("disable not applied");
  a_set_waits: assert property (
    core.boundary && s_reg.st == VIS_RUN && core.cmd == VIS_CMD_SET_GIE
    |=> processor_status_register[VIS_GIE_BIT] && s_reg.hold_one)
    else $error("enable without one instruction gap");
  a_hold_skip: assert property (
    core.boundary && s_reg.st == VIS_RUN && s_reg.hold_one &&
    core.cmd == VIS_CMD_NONE
    |=> !core_stall)
    else $error("entry inside the one instruction gap");
  a_busy_waits: assert property (
    core.boundary && s_reg.st == VIS_RUN && core.multi_busy &&
    core.cmd == VIS_CMD_NONE
    |=> !core_stall)
    else $error("entry during multi-cycle instruction");

  // flag and status bookkeeping; a fresh event may legally re-set a flag
  a_flag_taken: assert property (
    $rose(core_stall) && !in_return && !LEVEL_SRC[s_reg.vec] &&
    !$past(|ev_rise)
    |-> !flag_out[s_reg.vec])
    else $error("taken flag not cleared");
  a_wr_clears: assert property (
    |(flag_clear_wr & ~ev_rise)
    |=> (flag_out & $past(flag_clear_wr & ~ev_rise)) == '0)
    else $error("flag survives write of one");
  a_status_keep: assert property (
    $rose(core_stall) && !$past(core.status_we)
    |-> processor_status_register[6:0] ==
        $past(processor_status_register[6:0]))
    else $error("status touched by sequencer");

  // stack traffic: low byte first on push, high byte first on pop
  a_push_low: assert property (
    in_entry && s_reg.cnt == 3'h1
    |-> stack_req.we && stack_req.addr == sp_out &&
        stack_req.wdata == s_reg.ret_pc[7:0])
    else $error("low byte push wrong");
  a_push_high: assert property (
    in_entry && s_reg.cnt == 3'h2
    |-> stack_req.we && stack_req.addr == 8'(sp_out + 8'h01))
    else $error("high byte push wrong");
  a_pop_high: assert property (
    in_return && s_reg.cnt == 3'h0
    |-> stack_req.re && stack_req.addr == 8'(sp_out + 8'h01))
    else $error("high byte pop wrong");
  a_pop_low: assert property (
    in_return && s_reg.cnt == 3'h1
    |-> stack_req.re && stack_req.addr == 8'(sp_out + 8'h02))
    else $error("low byte pop wrong");

  c_entry: cover property ($rose(in_entry));
  c_return: cover property ($rose(in_return));
  c_nested: cover property (in_entry && processor_status_register[7]);
  c_wake: cover property ($rose(core_stall) && !in_entry && !in_return);
  c_level: cover property ($rose(core_stall) && !in_return &&
    LEVEL_SRC[s_reg.vec]);
endmodule : vis_seq
`default_nettype wire

// ==== test/vis_stack_mem.sv ====
// stack memory model standing behind the sequencer's stack port
`timescale 1ns/10ps
`default_nettype none
module vis_stack_mem
  import vis_pkg::*;
(
  input  wire logic       core_clk,
  input  wire vis_stack_t stack_req,
  output logic [7:0]      stack_rdata
);
  logic [7:0] mem [256];
  always_ff @(posedge core_clk) begin
    if (stack_req.we) begin
      mem[stack_req.addr] <= stack_req.wdata;
    end
  end
  // the byte answers in the cycle its address stands on the port;
  // no read pending: show a pattern, never a stale byte that could pass
  assign stack_rdata = stack_req.re ? mem[stack_req.addr]
                                    : ~stack_req.addr;
endmodule : vis_stack_mem
`default_nettype wire

// ==== test/test_vectored_interrupt_sequencer.sv ====
// self-checking bench for the vectored interrupt sequencer
`timescale 1ns/10ps
`default_nettype none
module test_vectored_interrupt_sequencer
  import vis_pkg::*;
;
  logic       core_clk, arst_n, sp_we;
  vis_core_t  core;
  logic [8:0] pc_in, src_event, src_level, src_enable, flag_clear_wr;
  logic [7:0] sp_wdata, stack_rdata, status, sp_out;
  logic [8:0] flag_out, pc;
  vis_stack_t stack_req;
  logic       core_stall, pc_load, in_entry, in_return;
  int         mismatches, num_checks;

  vis_seq #(.LEVEL_SRC(9'h100)) i_dut (
    .core_clk(core_clk), .arst_n(arst_n), .core(core), .pc_in(pc_in),
    .src_event(src_event), .src_level(src_level),
    .src_enable(src_enable), .flag_clear_wr(flag_clear_wr),
    .sp_we(sp_we), .sp_wdata(sp_wdata), .stack_rdata(stack_rdata),
    .flag_out(flag_out), .processor_status_register(status),
    .sp_out(sp_out), .stack_req(stack_req), .core_stall(core_stall),
    .pc_load(pc_load), .program_counter(pc), .in_entry(in_entry),
    .in_return(in_return)
  );
  vis_stack_mem i_mem (
    .core_clk(core_clk), .stack_req(stack_req), .stack_rdata(stack_rdata)
  );

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic wrap_up();
    if (mismatches == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // inputs always move 1 ns after the edge
  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step

  task automatic bnd(vis_cmd_t c, logic busy = 1'b0);
    core.boundary   = 1'b1;
    core.cmd        = c;
    core.multi_busy = busy;
    step(1);
    core.boundary   = 1'b0;
    core.cmd        = VIS_CMD_NONE;
    core.multi_busy = 1'b0;
  endtask : bnd

  // count sequence cycles, then expect the counter load
  task automatic land(logic [8:0] dest, int cyc);
    int n;
    n = 0;
    // stall covers wake, entry and return alike
    while (core_stall === 1'b1 && n < 20) begin
      n++;
      step(1);
    end
    chk("seq_cycles", cyc, n);
    chk("pc_load", 1, pc_load);
    chk("program_counter", dest, pc);
  endtask : land

  // one-cycle pulse, then room for the two-stage synchroniser
  task automatic fire(logic [8:0] m);
    src_event = m;
    step(1);
    src_event = '0;
    step(4);
  endtask : fire

  task automatic t_flags();
    chk("status", 16'h0, status);
    chk("program_counter", 16'h0, pc);
    fire(9'h00a);
    chk("flag_out", 16'h00a, flag_out);
    bnd(VIS_CMD_NONE);
    chk("in_entry", 0, in_entry);
    flag_clear_wr = 9'h008;
    step(1);
    flag_clear_wr = '0;
    step(1);
    chk("flag_out", 16'h002, flag_out);
    fire(9'h008);
  endtask : t_flags

  task automatic t_prio();
    src_enable = 9'h00a;
    bnd(VIS_CMD_SET_GIE);
    bnd(VIS_CMD_NONE);
    chk("in_entry", 0, in_entry);
    pc_in = 9'h155;
    bnd(VIS_CMD_NONE);
    chk("in_entry", 1, in_entry);
    chk("gie", 0, status[7]);
    chk("flag_out", 16'h008, flag_out);
    land(9'h002, 4);
    chk("sp_out", 16'h9d, sp_out);
    bnd(VIS_CMD_RETURN);
    land(9'h155, 4);
    chk("sp_out", 16'h9f, sp_out);
    chk("gie", 1, status[7]);
    chk("status", 16'h80, status);
    bnd(VIS_CMD_NONE);
    chk("in_entry", 0, in_entry);
    bnd(VIS_CMD_NONE);
    land(9'h004, 4);
  endtask : t_prio

  // still inside the last handler: level source, disable, nesting, wake
  task automatic t_nest();
    src_enable = 9'h1ff;
    src_level  = 9'h100;
    step(3);
    src_level  = '0;
    step(3);
    bnd(VIS_CMD_SET_GIE);
    bnd(VIS_CMD_NONE);
    bnd(VIS_CMD_NONE);
    chk("in_entry", 0, in_entry);
    src_level = 9'h100;
    step(3);
    bnd(VIS_CMD_CLR_GIE);
    chk("in_entry", 0, in_entry);
    bnd(VIS_CMD_SET_GIE);
    bnd(VIS_CMD_NONE);
    bnd(VIS_CMD_NONE, 1'b1);
    chk("in_entry", 0, in_entry);
    core.sleeping = 1'b1;
    bnd(VIS_CMD_NONE);
    core.sleeping = 1'b0;
    land(9'h009, 8);
    src_level = '0;
  endtask : t_nest

  initial begin
    repeat (2000) @(posedge core_clk);
    mismatches++;
    wrap_up();
  end

  initial begin
    arst_n        = 1'b0;
    core          = '0;
    pc_in         = '0;
    src_event     = '0;
    src_level     = '0;
    src_enable    = '0;
    flag_clear_wr = '0;
    sp_we         = 1'b0;
    sp_wdata      = '0;
    mismatches    = 0;
    num_checks    = 0;
    repeat (16) @(posedge core_clk);
    #1 arst_n = 1'b1;
    step(1);
    chk("sp_out", 16'h9f, sp_out);
    t_flags();
    t_prio();
    t_nest();
    wrap_up();
  end
endmodule : test_vectored_interrupt_sequencer
`default_nettype wire
